// file: hdl/usart_defines.vh
// Register map, field positions, reset values and counts of the serial port
`ifndef USART_DEFINES_VH
`define USART_DEFINES_VH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_GLOBAL_INT      8'h0B
`define IDX_PERIPH_FLAGS    8'h0C
`define IDX_RX_STATUS       8'h18
`define IDX_TX_HOLDING      8'h19
`define IDX_RX_HOLDING      8'h1A
`define IDX_PERIPH_ENABLES  8'h8C
`define IDX_TX_STATUS       8'h98
`define IDX_BAUD_DIVISOR    8'h99
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TXS_CLOCK_SOURCE    7
`define TXS_NINTH_EN        6
`define TXS_TX_ENABLE       5
`define TXS_CLOCKED_MODE    4
`define TXS_HIGH_SPEED      2
`define TXS_SHIFT_EMPTY     1
`define TXS_NINTH_VALUE     0
`define RCS_PORT_ENABLE     7
`define RCS_NINTH_EN        6
`define RCS_SINGLE_RX       5
`define RCS_CONT_RX         4
`define RCS_ADDR_DETECT     3
`define RCS_FRAMING_ERR     2
`define RCS_OVERRUN_ERR     1
`define RCS_NINTH_VALUE     0
`define PF_RX_FLAG          5
`define PF_TX_FLAG          4
`define GI_GLOBAL_EN        7
`define GI_PERIPH_EN        6
// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define RST_BYTE            8'h00
`define TXS_WRITE_MASK      8'hF5
`define RCS_WRITE_MASK      8'hF8
`define PF_WRITE_MASK       8'h00
// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define OVERSAMPLE_HALF     4'h7
`define OVERSAMPLE_LAST     4'hF
`define WORD_BITS_8         4'h8
`define WORD_BITS_9         4'h9
`endif

// file: hdl/usart_sync_master_tx_addr_detect.v
// Clocked master transmitter and 9-bit receiver with address detect, APB slave
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`include "usart_defines.vh"

module usart_sync_master_tx_addr_detect (
    // System
    input  wire        clk_sys,
    input  wire        nrst,
    // APB slave
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Shift clock pin
    input  wire        shift_clock_line_i,
    output reg         shift_clock_line_o,
    output reg         shift_clock_line_oe,
    // Serial data pin
    input  wire        serial_data_line_i,
    output reg         serial_data_line_o,
    output reg         serial_data_line_oe,
    // Interrupt request
    output reg         irq
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function mapped;
        input [11:0] a;
        begin
            mapped = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
                     (a[9:2] == `IDX_GLOBAL_INT || a[9:2] == `IDX_PERIPH_FLAGS ||
                      a[9:2] == `IDX_RX_STATUS || a[9:2] == `IDX_TX_HOLDING ||
                      a[9:2] == `IDX_RX_HOLDING || a[9:2] == `IDX_PERIPH_ENABLES ||
                      a[9:2] == `IDX_TX_STATUS || a[9:2] == `IDX_BAUD_DIVISOR);
        end
    endfunction

    reg  [7:0]  gic_reg;
    reg  [7:0]  pie_reg;
    reg  [7:0]  txs_reg;
    reg  [7:0]  rcs_reg;
    reg  [7:0]  baud_divisor_reg;
    reg  [7:0]  hold_reg;
    reg         hold_full_reg;
    reg         tx_flag_reg;
    reg  [8:0]  tsr_reg;
    reg         tsr_busy_reg;
    reg  [3:0]  tx_bit_reg;
    reg         ck_reg;
    reg  [7:0]  brg_cnt_reg;
    reg  [1:0]  dt_sync_reg;
    reg         rx_busy_reg;
    reg  [3:0]  rx_os_reg;
    reg  [3:0]  rx_bit_reg;
    reg  [8:0]  rsr_reg;
    reg         overrun_error_flag_reg;
    reg  [9:0]  fifo_mem [0:1];
    reg         fifo_head_reg;
    reg  [1:0]  fifo_cnt_reg;
    reg  [7:0]  rdata_next;

    wire        wr_en   = psel & penable & pready & pwrite & ~pslverr;
    wire        rd_en   = psel & penable & pready & ~pwrite & ~pslverr;
    wire [7:0]  widx    = paddr[9:2];
    wire [7:0]  wbyte   = pwdata[7:0];
    wire        port_en = rcs_reg[`RCS_PORT_ENABLE];
    wire        sync    = txs_reg[`TXS_CLOCKED_MODE];
    wire        master  = txs_reg[`TXS_CLOCK_SOURCE];
    wire        transmit_enable    = txs_reg[`TXS_TX_ENABLE];
    wire        continuous_receive_enable    = rcs_reg[`RCS_CONT_RX];
    wire        single_receive_enable    = rcs_reg[`RCS_SINGLE_RX];
    wire        rx_en   = continuous_receive_enable | single_receive_enable;
    wire        brg_run = transmit_enable | rx_en;
    wire        tick    = brg_run & (brg_cnt_reg == baud_divisor_reg);
    wire        dt_in   = dt_sync_reg[1];
    wire        smode   = port_en & sync & master;
    // Receive enables win over transmit while both are set
    wire        tx_live = smode & transmit_enable & ~rx_en;
    wire        rx_sync = smode & rx_en;
    wire [3:0]  tx_last = txs_reg[`TXS_NINTH_EN] ? `WORD_BITS_9 : `WORD_BITS_8;
    wire [3:0]  rx_last = rcs_reg[`RCS_NINTH_EN] ? `WORD_BITS_9 : `WORD_BITS_8;
    wire        do_load = tx_live & ~tsr_busy_reg & hold_full_reg;
    wire        hold_wr = wr_en & (widx == `IDX_TX_HOLDING);
    wire [9:0]  head    = fifo_mem[fifo_head_reg];
    wire        rx_flag = (fifo_cnt_reg != 2'h0);

    // ----------------------------------------------------------------
    // Pin input synchroniser
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dt_sync_reg <= 2'h3;
        end else begin
            dt_sync_reg <= {dt_sync_reg[0], serial_data_line_i};
        end
    end

    // ----------------------------------------------------------------
    // Baud generator
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            brg_cnt_reg <= 8'h00;
        end else if (!brg_run || tick) begin
            brg_cnt_reg <= 8'h00;
        end else begin
            brg_cnt_reg <= brg_cnt_reg + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // APB slave: zero wait states, error on unmapped address
    // ----------------------------------------------------------------
    always @* begin
        rdata_next = 8'h00;
        if (paddr[9:2] == `IDX_GLOBAL_INT) begin
            rdata_next = gic_reg;
        end else if (paddr[9:2] == `IDX_PERIPH_FLAGS) begin
            rdata_next[`PF_RX_FLAG] = rx_flag;
            rdata_next[`PF_TX_FLAG] = tx_flag_reg;
        end else if (paddr[9:2] == `IDX_RX_STATUS) begin
            rdata_next = rcs_reg & `RCS_WRITE_MASK;
            rdata_next[`RCS_FRAMING_ERR] = rx_flag & head[9];
            rdata_next[`RCS_OVERRUN_ERR] = overrun_error_flag_reg;
            rdata_next[`RCS_NINTH_VALUE] = rx_flag & head[8];
        end else if (paddr[9:2] == `IDX_TX_HOLDING) begin
            rdata_next = hold_reg;
        end else if (paddr[9:2] == `IDX_RX_HOLDING) begin
            rdata_next = rx_flag ? head[7:0] : 8'h00;
        end else if (paddr[9:2] == `IDX_PERIPH_ENABLES) begin
            rdata_next = pie_reg;
        end else if (paddr[9:2] == `IDX_TX_STATUS) begin
            rdata_next = txs_reg & `TXS_WRITE_MASK;
            rdata_next[`TXS_SHIFT_EMPTY] = ~tsr_busy_reg;
        end else if (paddr[9:2] == `IDX_BAUD_DIVISOR) begin
            rdata_next = baud_divisor_reg;
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= mapped(paddr) ? {24'h000000, rdata_next} : 32'h00000000;
            pready  <= 1'b1;
            pslverr <= ~mapped(paddr);
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            gic_reg          <= `RST_BYTE;
            pie_reg          <= `RST_BYTE;
            txs_reg          <= `RST_BYTE;
            rcs_reg          <= `RST_BYTE;
            baud_divisor_reg <= `RST_BYTE;
        end else begin
            if (wr_en && widx == `IDX_GLOBAL_INT) begin
                gic_reg <= wbyte;
            end
            if (wr_en && widx == `IDX_PERIPH_ENABLES) begin
                pie_reg <= wbyte;
            end
            if (wr_en && widx == `IDX_BAUD_DIVISOR) begin
                baud_divisor_reg <= wbyte;
            end
            if (wr_en && widx == `IDX_TX_STATUS) begin
                txs_reg <= wbyte & `TXS_WRITE_MASK;
            end
            if (wr_en && widx == `IDX_RX_STATUS) begin
                rcs_reg <= wbyte & `RCS_WRITE_MASK;
            end else if (rx_sync && !continuous_receive_enable && tick && ck_reg &&
                         rx_bit_reg == rx_last - 4'h1) begin
                // Single word done: hand the pins back to the transmitter
                rcs_reg[`RCS_SINGLE_RX] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Transmit holding register and flag
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hold_reg      <= `RST_BYTE;
            hold_full_reg <= 1'b0;
            tx_flag_reg   <= 1'b0;
        end else begin
            if (hold_wr) begin
                hold_reg      <= wbyte;
                hold_full_reg <= 1'b1;
                tx_flag_reg   <= 1'b0;
            end else if (do_load) begin
                hold_full_reg <= 1'b0;
                tx_flag_reg   <= 1'b1;
            end else if (!transmit_enable && tsr_busy_reg) begin
                hold_full_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Transmit shift register and shift clock
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tsr_reg      <= 9'h000;
            tsr_busy_reg <= 1'b0;
            tx_bit_reg   <= 4'h0;
            ck_reg       <= 1'b0;
        end else if (!transmit_enable && !rx_sync) begin
            tsr_busy_reg <= 1'b0;
            tx_bit_reg   <= 4'h0;
            ck_reg       <= 1'b0;
        end else if (rx_sync) begin
            // Transmit state frozen, receiver owns the clock
            if (tick) begin
                ck_reg <= ~ck_reg;
            end
        end else if (do_load) begin
            // Ninth bit taken now, so a late ninth-bit write misses it
            tsr_reg      <= {txs_reg[`TXS_NINTH_VALUE], hold_reg};
            tsr_busy_reg <= 1'b1;
            tx_bit_reg   <= 4'h0;
            ck_reg       <= 1'b0;
        end else if (tx_live && tsr_busy_reg && tick) begin
            ck_reg <= ~ck_reg;
            if (ck_reg) begin
                tx_bit_reg <= tx_bit_reg + 4'h1;
                if (tx_bit_reg == tx_last - 4'h1) begin
                    tsr_busy_reg <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            shift_clock_line_o  <= 1'b0;
            shift_clock_line_oe <= 1'b0;
            serial_data_line_o  <= 1'b1;
            serial_data_line_oe <= 1'b0;
        end else begin
            shift_clock_line_o  <= ck_reg;
            shift_clock_line_oe <= smode & brg_run;
            serial_data_line_oe <= tx_live;
            // Bit changes with the rising edge, steady over the falling one
            if (tx_live && tsr_busy_reg && ck_reg && !shift_clock_line_o) begin
                serial_data_line_o <= tsr_reg[tx_bit_reg];
            end
        end
    end

    // ----------------------------------------------------------------
    // Receiver: clocked (falling edge) or async 16x oversampled
    // ----------------------------------------------------------------
    wire        rx_done_sync = rx_sync & tick & ck_reg &
                               (rx_bit_reg == rx_last - 4'h1);
    wire        async_on     = port_en & ~sync & continuous_receive_enable;
    wire        stop_at      = async_on & rx_busy_reg & tick &
                               (rx_os_reg == `OVERSAMPLE_LAST) &
                               (rx_bit_reg == rx_last + 4'h1);
    wire [8:0]  rx_word      = rx_done_sync ?
                               (rcs_reg[`RCS_NINTH_EN] ? {dt_in, rsr_reg[8:1]}
                                                       : {1'b0, dt_in, rsr_reg[8:2]})
                               : (rcs_reg[`RCS_NINTH_EN] ? rsr_reg
                                                         : {1'b0, rsr_reg[8:1]});
    wire        rx_done      = rx_done_sync | stop_at;
    // Address words only, while detect is enabled in async mode
    wire        keep         = ~(stop_at & rcs_reg[`RCS_ADDR_DETECT]) | rx_word[8];
    wire        rd_pop       = rd_en & (widx == `IDX_RX_HOLDING) & rx_flag;
    wire        push         = rx_done & keep & ~overrun_error_flag_reg & (fifo_cnt_reg != 2'h2 | rd_pop);

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_busy_reg <= 1'b0;
            rx_os_reg   <= 4'h0;
            rx_bit_reg  <= 4'h0;
            rsr_reg     <= 9'h000;
        end else if (!rx_sync && !async_on) begin
            rx_busy_reg <= 1'b0;
            rx_os_reg   <= 4'h0;
            rx_bit_reg  <= 4'h0;
        end else if (rx_sync) begin
            if (tick && ck_reg) begin
                rsr_reg    <= {dt_in, rsr_reg[8:1]};
                rx_bit_reg <= rx_done_sync ? 4'h0 : rx_bit_reg + 4'h1;
            end
        end else if (!rx_busy_reg) begin
            if (!dt_in) begin
                rx_busy_reg <= 1'b1;
                rx_os_reg   <= `OVERSAMPLE_HALF;
                rx_bit_reg  <= 4'h0;
            end
        end else if (tick) begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == `OVERSAMPLE_LAST) begin
                rx_bit_reg <= rx_bit_reg + 4'h1;
                if (rx_bit_reg == 4'h0 && dt_in) begin
                    rx_busy_reg <= 1'b0; // False start
                end else if (stop_at) begin
                    rx_busy_reg <= 1'b0;
                end else if (rx_bit_reg != 4'h0) begin
                    rsr_reg <= {dt_in, rsr_reg[8:1]};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Two-word receive queue with framing error and ninth bit
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fifo_head_reg <= 1'b0;
            fifo_cnt_reg  <= 2'h0;
            overrun_error_flag_reg      <= 1'b0;
            fifo_mem[0]   <= 10'h000;
            fifo_mem[1]   <= 10'h000;
        end else begin
            if (push) begin
                fifo_mem[fifo_head_reg ^ (fifo_cnt_reg != 2'h0 && !(rd_pop &&
                         fifo_cnt_reg == 2'h1)) ^ rd_pop] <=
                    {stop_at & ~dt_in, rx_word};
            end
            if (rd_pop) begin
                fifo_head_reg <= ~fifo_head_reg;
            end
            if (push && !rd_pop) begin
                fifo_cnt_reg <= fifo_cnt_reg + 2'h1;
            end else if (rd_pop && !push) begin
                fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
            end
            // Overrun sticks until continuous receive is cleared
            if (!continuous_receive_enable) begin
                overrun_error_flag_reg <= 1'b0;
            end else if (rx_done && keep && fifo_cnt_reg == 2'h2 && !rd_pop) begin
                overrun_error_flag_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt request
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= gic_reg[`GI_GLOBAL_EN] & gic_reg[`GI_PERIPH_EN] &
                   ((rx_flag & pie_reg[`PF_RX_FLAG]) |
                    (tx_flag_reg & pie_reg[`PF_TX_FLAG]));
        end
    end

endmodule // usart_sync_master_tx_addr_detect

// file: test/usart_chk.sv
// Checker for bus answers and pin timing of the serial port
`timescale 1ns/10ps
module usart_chk (
    // System
    input wire logic        clk_sys,
    input wire logic        nrst,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic        shift_clock_line_o,
    input wire logic        shift_clock_line_oe,
    input wire logic        serial_data_line_o,
    input wire logic        serial_data_line_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    zero_wait_a: assert property (psel && !penable |=> pready)
        else $error("bus answer missing");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_zero_a: assert property (pslverr |-> pready && prdata == 32'h00000000)
        else $error("refused access returned data");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    data_clock_a: assert property (serial_data_line_oe |-> shift_clock_line_oe)
        else $error("data driven without clock");
    data_hold_a: assert property ($fell(shift_clock_line_o) && serial_data_line_oe
        |-> $stable(serial_data_line_o) ##1 $stable(serial_data_line_o))
        else $error("data moved at falling clock");
    data_rise_a: assert property (serial_data_line_oe && $past(serial_data_line_oe)
        && $changed(serial_data_line_o) |-> $rose(shift_clock_line_o))
        else $error("data moved without rising clock");
    cover property (psel && penable && pready);
    cover property ($rose(serial_data_line_oe));
    cover property (pslverr);
endmodule // usart_chk
bind usart_sync_master_tx_addr_detect usart_chk chk_u (.clk_sys(clk_sys), .nrst(nrst),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_clock_line_o(shift_clock_line_o), .shift_clock_line_oe(shift_clock_line_oe),
    .serial_data_line_o(serial_data_line_o), .serial_data_line_oe(serial_data_line_oe));

// file: test/usart_slave_model.sv
// Far side model: clocked slave shifting words in, and an async sender
`timescale 1ns/10ps
module usart_slave_model (
    // System
    input  wire logic clk_sys,
    // Port pins
    input  wire logic ck_o,
    input  wire logic ck_oe,
    input  wire logic dt_o,
    input  wire logic dt_oe,
    output wire logic dt_in
);
    logic        ck_d  = 1'b0;
    logic        last  = 1'b1;
    logic        line  = 1'b1;
    logic        drive = 1'b0;
    logic [15:0] sr    = 16'h0000;
    int          cnt   = 0;
    // No pull on the line: released it shows the inverse level
    assign dt_in = dt_oe ? dt_o : (drive ? line : ~last);
    always @(posedge clk_sys) begin
        ck_d <= ck_o;
        if (dt_oe)
            last <= dt_o;
        if (ck_d && !ck_o && ck_oe && dt_oe) begin
            sr  <= {dt_o, sr[15:1]};
            cnt <= cnt + 1;
        end
    end
    task automatic send_async(input logic [8:0] w, input int bt);
        logic [10:0] f;
        f = {1'b1, w, 1'b0};
        drive <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            line <= f[i];
            repeat (bt) @(posedge clk_sys);
        end
    endtask
endmodule // usart_slave_model

// file: test/test_usart_sync_master_tx_addr_detect.sv
// Bench: register access, clocked transmit, async address detect
`timescale 1ns/10ps
`include "usart_defines.vh"
module test_usart_sync_master_tx_addr_detect;
    logic        clk_sys = 1'b0;
    logic        nrst    = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h00000000;
    wire  [31:0] prdata;
    wire         pready, pslverr, ck_o, ck_oe, dt_o, dt_oe, dt_in, irq;
    wire         ck_in = ck_oe ? ck_o : ~ck_o;
    int          fail_count = 0;
    int          checks     = 0;
    int          cyc        = 0;
    logic [7:0]  rd;
    logic        er;
    always #10 clk_sys = ~clk_sys;
    usart_sync_master_tx_addr_detect dut_u (.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .shift_clock_line_i(ck_in),
        .shift_clock_line_o(ck_o), .shift_clock_line_oe(ck_oe), .serial_data_line_i(dt_in),
        .serial_data_line_o(dt_o), .serial_data_line_oe(dt_oe), .irq(irq));
    usart_slave_model model_u (.clk_sys(clk_sys), .ck_o(ck_o), .ck_oe(ck_oe), .dt_o(dt_o),
        .dt_oe(dt_oe), .dt_in(dt_in));
    task automatic stop_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= {2'b00, idx, 2'b00};
        pwrite  <= w;
        pwdata  <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string n, input logic [7:0] idx, input logic [7:0] e);
        apb(idx, 1'b0, 8'h00);
        chk(n, {8'h00, e}, {8'h00, rd});
    endtask
    task automatic wait_bits(input int b);
        while (model_u.cnt < b)
            @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        rdc("tx_status", `IDX_TX_STATUS, 8'h02);
        rdc("flags", `IDX_PERIPH_FLAGS, 8'h00);
        apb(8'h01, 1'b0, 8'h00);
        chk("unmapped", 16'h0001, {15'h0000, er});
        apb(`IDX_BAUD_DIVISOR, 1'b1, 8'h03);
        apb(`IDX_TX_STATUS, 1'b1, 8'hB0);
        apb(`IDX_TX_HOLDING, 1'b1, 8'h11);
        repeat (20) @(posedge clk_sys);
        chk("oe port off", 16'h0000, {14'h0000, ck_oe, dt_oe});
        apb(`IDX_TX_STATUS, 1'b1, 8'h90);
        rdc("tx_status", `IDX_TX_STATUS, 8'h92);
        // Holding loaded before the enable
        apb(`IDX_RX_STATUS, 1'b1, 8'h80);
        apb(`IDX_TX_HOLDING, 1'b1, 8'h81);
        model_u.cnt = 0;
        apb(`IDX_TX_STATUS, 1'b1, 8'hB0);
        wait_bits(8);
        chk("word", 16'h0081, {8'h00, model_u.sr[15:8]});
        apb(`IDX_TX_HOLDING, 1'b1, 8'hA5);
        rdc("flags", `IDX_PERIPH_FLAGS, 8'h10);
        rdc("tx_status", `IDX_TX_STATUS, 8'hB0);
        apb(`IDX_TX_HOLDING, 1'b1, 8'h3C);
        rdc("flags", `IDX_PERIPH_FLAGS, 8'h00);
        wait_bits(24);
        chk("two words", 16'h3CA5, model_u.sr);
        do
            apb(`IDX_TX_STATUS, 1'b0, 8'h00);
        while (rd[1] !== 1'b1);
        chk("tx_status", 16'h00B2, {8'h00, rd});
        apb(`IDX_PERIPH_FLAGS, 1'b1, 8'h00);
        rdc("flags", `IDX_PERIPH_FLAGS, 8'h10);
        model_u.cnt = 0;
        apb(`IDX_TX_STATUS, 1'b1, 8'hF1);
        apb(`IDX_TX_HOLDING, 1'b1, 8'h55);
        wait_bits(9);
        chk("nine bits", 16'h0155, {7'h00, model_u.sr[15:7]});
        apb(`IDX_TX_STATUS, 1'b1, 8'hB0);
        apb(`IDX_TX_HOLDING, 1'b1, 8'hFF);
        repeat (12) @(posedge clk_sys);
        apb(`IDX_TX_STATUS, 1'b1, 8'h90);
        repeat (2) @(posedge clk_sys);
        chk("oe abort", 16'h0000, {14'h0000, ck_oe, dt_oe});
        rdc("tx_status", `IDX_TX_STATUS, 8'h92);
        apb(`IDX_TX_STATUS, 1'b1, 8'hB0);
        apb(`IDX_TX_HOLDING, 1'b1, 8'h0F);
        repeat (12) @(posedge clk_sys);
        apb(`IDX_RX_STATUS, 1'b1, 8'h90);
        repeat (2) @(posedge clk_sys);
        chk("oe receive", 16'h0002, {14'h0000, ck_oe, dt_oe});
        // Single word receive, then the transmitter takes the data pin back
        apb(`IDX_RX_STATUS, 1'b1, 8'hA0);
        do
            apb(`IDX_RX_STATUS, 1'b0, 8'h00);
        while (rd[5] !== 1'b0);
        chk("single clear", 16'h0080, {8'h00, rd});
        repeat (2) @(posedge clk_sys);
        chk("oe resume", 16'h0003, {14'h0000, ck_oe, dt_oe});
        rdc("flags", `IDX_PERIPH_FLAGS, 8'h30);
        apb(`IDX_RX_HOLDING, 1'b0, 8'h00);
        rdc("flags", `IDX_PERIPH_FLAGS, 8'h10);
        // Async 9-bit reception with address detect
        apb(`IDX_TX_STATUS, 1'b1, 8'h00);
        apb(`IDX_RX_STATUS, 1'b1, 8'h00);
        model_u.line <= 1'b1;
        model_u.drive <= 1'b1;
        apb(`IDX_GLOBAL_INT, 1'b1, 8'hC0);
        apb(`IDX_PERIPH_ENABLES, 1'b1, 8'h20);
        apb(`IDX_RX_STATUS, 1'b1, 8'hD8);
        model_u.send_async(9'h034, 64);
        apb(`IDX_PERIPH_FLAGS, 1'b0, 8'h00);
        chk("data dropped", 16'h0000, {15'h0000, rd[5]});
        model_u.send_async(9'h1A7, 64);
        repeat (4) @(posedge clk_sys);
        chk("irq set", 16'h0001, {15'h0000, irq});
        rdc("rx_status", `IDX_RX_STATUS, 8'hD9);
        rdc("address", `IDX_RX_HOLDING, 8'hA7);
        repeat (2) @(posedge clk_sys);
        chk("irq clear", 16'h0000, {15'h0000, irq});
        apb(`IDX_RX_STATUS, 1'b1, 8'hD0);
        model_u.send_async(9'h042, 64);
        repeat (4) @(posedge clk_sys);
        rdc("rx_status", `IDX_RX_STATUS, 8'hD0);
        rdc("data", `IDX_RX_HOLDING, 8'h42);
        stop_test();
    end
endmodule // test_usart_sync_master_tx_addr_detect
